// [verif/cpu_seq_model.sv]
/*
 * Behavioural model of the CPU exception sequencer.
 * Assumes the block's take pulses are registered and that exc_begin comes from the bench.
 */
`timescale 1ns/1ps

module cpu_seq_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic int_take,
	input wire logic ae_take,
	input wire logic exc_begin,
	output logic stack_push,
	output logic vector_fetch,
	output logic exc_done
);
	logic [2:0] step_r;

	// Runs two pushes, one vector fetch and the finish pulse after each start.
	always_ff @(posedge clk) begin
		if (srst) begin
			step_r <= 3'h0;
		end else if (step_r != 3'h0) begin
			step_r <= (step_r == 3'h4) ? 3'h0 : step_r + 3'h1;
		end else if (int_take | ae_take | exc_begin) begin
			step_r <= 3'h1;
		end
	end

	// Status word push first, then the program counter push.
	assign stack_push = (step_r == 3'h1) || (step_r == 3'h2);
	assign vector_fetch = (step_r == 3'h3);
	assign exc_done = (step_r == 3'h4);
endmodule // cpu_seq_model

// [verif/exception_accept_and_priority_controller_tb.sv]
/*
 * Self-checking bench for the acceptance gate and priority front end.
 * Assumes the sequencer model answers every take and exc_begin.
 */
`timescale 1ns/1ps
`include "priority_controller_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %0t: got %h want %h", $time, (g), (e)); end end

module exception_accept_and_priority_controller_tb import priority_controller_pkg::*;;
	logic clk, srst, nmi_pin, break_req, exc_begin, stack_push, vector_fetch, exc_done;
	logic int_take_r, ae_take_r, push_valid_r, push_data_defined_r, onchip_pending_out;
	logic rd_d = 1'b0;
	logic in_aex = 1'b0;
	reg_bus_t bus;
	decode_qual_t dq;
	logic [31:0] rdata, stack_pointer, vector_base, push_addr_r, seed;
	logic [27:0] a;
	logic [7:0] pins;
	logic [11:0] onchip_req;
	logic [3:0] mask, take_level_r;
	logic [4:0] take_src_r;
	logic [39:0] exp_q[$];
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;

	exception_accept_and_priority_controller dut_u (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
		.nmi_pin(nmi_pin), .external_request_pins(pins), .break_req(break_req),
		.onchip_req(onchip_req), .cpu_mask_level(mask), .dq(dq), .exc_begin(exc_begin),
		.exc_done(exc_done), .stack_pointer(stack_pointer), .stack_push(stack_push),
		.vector_base(vector_base), .vector_fetch(vector_fetch), .int_take_r(int_take_r),
		.take_src_r(take_src_r), .take_level_r(take_level_r), .ae_take_r(ae_take_r),
		.push_valid_r(push_valid_r), .push_addr_r(push_addr_r),
		.push_data_defined_r(push_data_defined_r), .onchip_pending_out(onchip_pending_out));

	cpu_seq_model cpu_u (.clk(clk), .srst(srst), .int_take(int_take_r), .ae_take(ae_take_r),
		.exc_begin(exc_begin), .stack_push(stack_push), .vector_fetch(vector_fetch),
		.exc_done(exc_done));

	// Free-running clock at 25 MHz.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
	endfunction

	task automatic results();
		if (n_fail == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Strobes stay up for back-to-back cycles until idle clears them.
	task automatic wr(input logic [27:0] ad, input logic [31:0] d, input logic [1:0] s);
		bus <= '{addr: ad, wdata: d, size: s, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
	endtask

	task automatic rd(input logic [27:0] ad, input logic [1:0] s, input logic [31:0] e);
		bus <= '{addr: ad, wdata: 32'h0, size: s, wr: 1'b0, rd: 1'b1};
		exp_q.push_back({8'h10, e});
		@(posedge clk);
	endtask

	task automatic idle(input int n);
		bus <= '0;
		dq <= '0;
		repeat (n) @(posedge clk);
	endtask

	task automatic dec(input decode_qual_t d, input int n);
		dq <= d;
		repeat (n) @(posedge clk);
	endtask

	task automatic ex_push(input logic def, input logic [31:0] ad);
		exp_q.push_back({4'h4, 3'h0, def, ad});
	endtask

	// Takes the oldest note and compares it; a result with no note fails.
	task automatic check(input logic [39:0] got);
		logic [39:0] e;
		e = (exp_q.size() == 0) ? ~got : exp_q.pop_front();
		`CHK(got, e)
	endtask

	// Watches every result; faulting data is not judged during address error stacking.
	always @(posedge clk) begin
		if (!srst) begin
			if (rd_d) check({8'h10, rdata});
			if (int_take_r) check({4'h2, 27'h0, take_src_r, take_level_r});
			if (ae_take_r) check({4'h3, 36'h0});
			if (push_valid_r) check({4'h4, 3'h0, push_data_defined_r & ~in_aex, push_addr_r});
		end
		rd_d <= bus.rd & ~srst;
		in_aex <= srst ? 1'b0 : ae_take_r ? 1'b1 : exc_done ? 1'b0 : in_aex;
	end

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		srst = 1'b1;
		bus = '0;
		dq = '0;
		nmi_pin = 1'b0;
		break_req = 1'b0;
		pins = 8'hff;
		onchip_req = 12'h0;
		mask = 4'h0;
		exc_begin = 1'b0;
		stack_pointer = 32'h1000;
		vector_base = 32'h100;
		seed = 32'h839f;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(`INPUT_DETECT_CONTROL_OFS, `SIZE_WORD, 32'h0);
		nmi_pin <= 1'b1;
		idle(3);
		rd(`INPUT_DETECT_CONTROL_OFS, `SIZE_WORD, 32'h8000);
		// Random words into all six registers, read back through an alias address.
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			a = `PRIORITY_REG_A_OFS + 28'(2 * i);
			wr(a, {16'h0, seed[15:0]}, `SIZE_WORD);
			rd(a ^ 28'h0aaaa00, `SIZE_WORD, (i == 5) ? {23'h040, seed[8:0]} : {16'h0, seed[15:0]});
		end
		wr(`PRIORITY_REG_A_OFS, 32'h12345678, `SIZE_LONG);
		wr(28'h5ffff87, 32'h000000ab, `SIZE_BYTE);
		rd(28'h5ffff86, `SIZE_BYTE, 32'h56);
		rd(`PRIORITY_REG_A_OFS, `SIZE_LONG, 32'h123456ab);
		rd(28'h5ffff86, `SIZE_LONG, 32'h0);
		rd(28'h5ffff90, `SIZE_WORD, 32'h0);
		rd(28'h4ffff84, `SIZE_WORD, 32'h0);
		for (int i = 1; i < 6; i++) wr(`PRIORITY_REG_A_OFS + 28'(2 * i), 32'h0, `SIZE_WORD);
		wr(`PRIORITY_REG_A_OFS, 32'h0005, `SIZE_WORD);
		mask <= 4'h2;
		idle(1);
		// Level request held off by slot positions, then taken.
		pins <= 8'hf7;
		dec('{1'b1, 1'b1, 1'b0}, 4);
		dec('{1'b1, 1'b0, 1'b1}, 4);
		exp_q.push_back({4'h2, 27'h0, 5'h05, 4'h5});
		ex_push(1'b1, 32'h0ffc);
		ex_push(1'b1, 32'h0ff8);
		dec('{1'b1, 1'b0, 1'b0}, 1);
		pins <= 8'hff;
		idle(12);
		mask <= 4'h5;
		pins <= 8'hf7;
		dec('{1'b1, 1'b0, 1'b0}, 4);
		pins <= 8'hff;
		idle(2);
		// Falling edge of the non-maskable pin, vector base misaligned.
		vector_base <= 32'h102;
		mask <= 4'hf;
		exp_q.push_back({4'h2, 27'h0, 5'h00, 4'hf});
		ex_push(1'b1, 32'h0ffc);
		ex_push(1'b1, 32'h0ff8);
		nmi_pin <= 1'b0;
		idle(2);
		dec('{1'b1, 1'b0, 1'b0}, 1);
		idle(12);
		vector_base <= 32'h100;
		exp_q.push_back({4'h3, 36'h0});
		ex_push(1'b0, 32'h0ffc);
		ex_push(1'b0, 32'h0ff8);
		dec('{1'b1, 1'b0, 1'b0}, 1);
		idle(12);
		// Misaligned stack pointer; errors during its own stacking are dropped.
		mask <= 4'h0;
		stack_pointer <= 32'h1002;
		idle(2);
		ex_push(1'b0, 32'h0ffe);
		ex_push(1'b0, 32'h0ffa);
		exc_begin <= 1'b1;
		@(posedge clk);
		exc_begin <= 1'b0;
		idle(10);
		dec('{1'b1, 1'b1, 1'b0}, 3);
		exp_q.push_back({4'h3, 36'h0});
		ex_push(1'b0, 32'h0ffe);
		ex_push(1'b0, 32'h0ffa);
		dec('{1'b1, 1'b0, 1'b1}, 1);
		idle(12);
		dec('{1'b1, 1'b0, 1'b0}, 4);
		// User break at fixed level 15, taken at once by the standing decode.
		stack_pointer <= 32'h1000;
		break_req <= 1'b1;
		exp_q.push_back({4'h2, 27'h0, 5'h01, 4'hf});
		ex_push(1'b1, 32'h0ffc);
		ex_push(1'b1, 32'h0ff8);
		dec('{1'b1, 1'b0, 1'b0}, 1);
		break_req <= 1'b0;
		idle(12);
		// Edge sense on a request pin: a short low pulse is remembered.
		wr(`INPUT_DETECT_CONTROL_OFS, 32'h0008, `SIZE_WORD);
		pins <= 8'hf7;
		idle(1);
		pins <= 8'hff;
		idle(2);
		exp_q.push_back({4'h2, 27'h0, 5'h05, 4'h5});
		ex_push(1'b1, 32'h0ffc);
		ex_push(1'b1, 32'h0ff8);
		dec('{1'b1, 1'b0, 1'b0}, 1);
		idle(12);
		// On-chip pending output against mask and level 0.
		wr(`PRIORITY_REG_C_OFS, 32'h3000, `SIZE_WORD);
		onchip_req <= 12'h001;
		mask <= 4'h2;
		idle(2);
		`CHK(onchip_pending_out, 1'b1)
		mask <= 4'h3;
		idle(2);
		`CHK(onchip_pending_out, 1'b0)
		mask <= 4'h2;
		wr(`PRIORITY_REG_C_OFS, 32'h0, `SIZE_WORD);
		idle(2);
		`CHK(onchip_pending_out, 1'b0)
		onchip_req <= 12'h0;
		idle(4);
		`CHK(exp_q.size(), 0)
		results();
	end
endmodule // exception_accept_and_priority_controller_tb

// [verilog/exception_accept_and_priority_controller.sv]
/*
 * Exception acceptance gate and interrupt priority front end.
 * Assumes the CPU core drives one decode qualifier per decoded instruction,
 * pulses exc_begin, stack_push, vector_fetch and exc_done, and that all
 * inputs are synchronous to clk.
 */
// Behaviour
// - Delay-slot decode accepts neither interrupts nor address errors.
// - Decode after interrupt-disabling instruction blocks interrupts, accepts address errors.
// - Held-off exceptions stay pending until an accepting decode.
// - Misaligned stack pointer during stacking raises an address error.
// - Misaligned vector base during vector fetch raises an address error.
// - Stacking error finishes current exception, then address error processing.
// - Stacking errors during address error processing are ignored.
// - Misaligned stacking write still issued; pointer drops by four each push.
// - Data of a faulting stacking write is undefined.
// - Five priority registers give each source one of 16 levels.
// - Readable bit shows the current non-maskable pin level.
// - Output pin flags pending on-chip interrupts, also with bus released.
// - Six read/write registers reachable by 8, 16 and 32 bit accesses.
// - Control register reads 8000 or 0000 after reset per pin.
// - Decode only A27-A24 and A8-A0; A23-A9 ignored.
// - Maskable interrupt accepted only above the CPU mask level.
// - Level 0 masks a source; reset sets every request pin and on-chip source to 0.
// - Non-maskable input edge sensed, edge selectable; sets mask 15.
// - Each request pin selects low-level or falling-edge sensing.
`timescale 1ns/1ps
`include "priority_controller_regs.svh"

module exception_accept_and_priority_controller
	import priority_controller_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire reg_bus_t bus,
	output logic [31:0] rdata,
	input wire logic nmi_pin,
	input wire logic [7:0] external_request_pins,
	input wire logic break_req,
	input wire logic [11:0] onchip_req,
	input wire logic [3:0] cpu_mask_level,
	input wire decode_qual_t dq,
	input wire logic exc_begin,
	input wire logic exc_done,
	input wire logic [31:0] stack_pointer,
	input wire logic stack_push,
	input wire logic [31:0] vector_base,
	input wire logic vector_fetch,
	output logic int_take_r,
	output logic [4:0] take_src_r,
	output logic [3:0] take_level_r,
	output logic ae_take_r,
	output logic push_valid_r,
	output logic [31:0] push_addr_r,
	output logic push_data_defined_r,
	output logic onchip_pending_out
);

	exc_state_t state_r;
	logic [15:0] ipr_r [5];
	logic nmi_edge_r;
	logic [7:0] sense_r;
	logic nmi_prev_r;
	logic nmi_flag_r;
	logic [7:0] pin_prev_r;
	logic [7:0] irq_flag_r;
	logic ae_pend_r;
	logic [31:0] sp_work_r;
	logic hit;
	logic [15:0] wval;
	logic [4:0] lvl [22];
	logic [21:0] pend;
	logic [4:0] best_lvl;
	logic [4:0] best_src;
	logic best_any;
	logic gate_ok;
	logic acc_int;
	logic acc_ae;
	logic nmi_edge_seen;
	logic [7:0] irq_fall;
	logic [31:0] rdata_nxt;
	logic onchip_any;
	logic [2:0] icr_ln;
	logic [15:0] icr_d;

	// Lanes of register lo9 hit by an access: {upper half, hi byte, lo byte}.
	function automatic logic [2:0] lanes(input logic [8:0] a, input logic [1:0] sz,
			input logic [8:0] lo);
		logic [2:0] r;
		r = 3'h0;
		case (sz)
			`SIZE_BYTE: begin
				if (a == lo)
					r = 3'h2;
				else if (a == lo + 9'h001)
					r = 3'h1;
			end
			`SIZE_WORD: begin
				if (a == lo)
					r = 3'h3;
			end
			`SIZE_LONG: begin
				if (a[1:0] == 2'h0 && a == lo)
					r = 3'h7;
				else if (a[1:0] == 2'h0 && a + 9'h002 == lo)
					r = 3'h3;
			end
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	// Four-bit priority field n of a priority register, n 0 is the top nibble.
	function automatic logic [4:0] field(input logic [15:0] r, input logic [1:0] n);
		logic [15:0] s;
		s = r << {n, 2'h0};
		return {1'b0, s[15:12]};
	endfunction

	// Address-space hit, A23-A9 left out of the compare.
	assign hit = bus.addr[27:24] == `REG_AREA;

	// Data lane that a write places in a register.
	always_comb begin
		if (bus.size == `SIZE_BYTE)
			wval = {bus.wdata[7:0], bus.wdata[7:0]};
		else if (bus.size == `SIZE_LONG && bus.addr[1:0] == 2'h0)
			wval = bus.wdata[15:0];
		else
			wval = bus.wdata[15:0];
	end

	// Five priority registers, reset to level 0 for every source.
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_ipr
			localparam logic [8:0] LO = `REG_LOW_BASE + 9'(2 * gi);
			logic [2:0] ln;
			logic [15:0] d;
			assign ln = lanes(bus.addr[8:0], bus.size, LO);
			assign d = ln[2] ? bus.wdata[31:16] : wval;
			always_ff @(posedge clk) begin
				if (srst) begin
					ipr_r[gi] <= `PRIORITY_RESET;
				end else if (bus.wr && hit) begin
					if (ln[1])
						ipr_r[gi][15:8] <= d[15:8];
					if (ln[0])
						ipr_r[gi][7:0] <= d[7:0];
				end
			end
		end
	endgenerate

	// Lanes and data that a write places in the control register.
	assign icr_ln = lanes(bus.addr[8:0], bus.size, `REG_LOW_BASE + 9'h00a);
	assign icr_d = icr_ln[2] ? bus.wdata[31:16] : wval;

	// Control register: edge select and sense selects; top bit is the live pin.
	always_ff @(posedge clk) begin
		if (srst) begin
			nmi_edge_r <= `ICR_EDGE_RESET;
			sense_r <= `ICR_SENSE_RESET;
		end else if (bus.wr && hit) begin
			if (icr_ln[1])
				nmi_edge_r <= icr_d[`ICR_NMI_EDGE_BIT];
			if (icr_ln[0])
				sense_r <= icr_d[7:0];
		end
	end

	// Read data, stands only in the cycle after the read strobe.
	always_comb begin
		rdata_nxt = 32'h0;
		for (int i = 0; i < 6; i++) begin
			logic [2:0] ln;
			logic [15:0] v;
			v = 16'h0;
			ln = lanes(bus.addr[8:0], bus.size, `REG_LOW_BASE + 9'(2 * i));
			if (i < 5)
				v = ipr_r[i];
			else
				v = {nmi_pin, 6'h0, nmi_edge_r, sense_r};
			if (ln[2])
				rdata_nxt = rdata_nxt | {v, 16'h0};
			else if (ln == 3'h3)
				rdata_nxt = rdata_nxt | {16'h0, v};
			else if (ln == 3'h2)
				rdata_nxt = rdata_nxt | {24'h0, v[15:8]};
			else if (ln == 3'h1)
				rdata_nxt = rdata_nxt | {24'h0, v[7:0]};
		end
		if (!hit)
			rdata_nxt = 32'h0;
	end

	// Read data register; unmapped addresses read zero.
	always_ff @(posedge clk) begin
		if (srst)
			rdata <= 32'h0;
		else if (bus.rd)
			rdata <= rdata_nxt;
		else
			rdata <= 32'h0;
	end

	// Edge detection on the non-maskable pin and the request pins.
	assign nmi_edge_seen = nmi_edge_r ? (nmi_pin && !nmi_prev_r) : (!nmi_pin && nmi_prev_r);
	assign irq_fall = pin_prev_r & ~external_request_pins;

	// Previous pin levels.
	always_ff @(posedge clk) begin
		if (srst) begin
			nmi_prev_r <= 1'b0;
			pin_prev_r <= 8'h00;
		end else begin
			nmi_prev_r <= nmi_pin;
			pin_prev_r <= external_request_pins;
		end
	end

	// Edge flags; a new edge wins over the clear from acceptance.
	always_ff @(posedge clk) begin
		if (srst) begin
			nmi_flag_r <= 1'b0;
			irq_flag_r <= 8'h00;
		end else begin
			if (nmi_edge_seen)
				nmi_flag_r <= 1'b1;
			else if (acc_int && best_src == `SRC_NMI)
				nmi_flag_r <= 1'b0;
			for (int k = 0; k < 8; k++) begin
				if (irq_fall[k])
					irq_flag_r[k] <= 1'b1;
				else if (acc_int && best_src == `SRC_IRQ0 + 5'(k))
					irq_flag_r[k] <= 1'b0;
			end
		end
	end

	// Levels and pending bits of all sources in default order.
	always_comb begin
		lvl[0] = `NMI_LEVEL;
		pend[0] = nmi_flag_r;
		lvl[1] = `BREAK_LEVEL;
		pend[1] = break_req;
		for (int k = 0; k < 8; k++) begin
			lvl[2 + k] = field(ipr_r[k / 4], 2'(k % 4));
			pend[2 + k] = sense_r[k] ? irq_flag_r[k] : !external_request_pins[k];
		end
		for (int j = 0; j < 12; j++) begin
			lvl[10 + j] = field(ipr_r[2 + j / 4], 2'(j % 4));
			pend[10 + j] = onchip_req[j];
		end
	end

	// Highest eligible source; a tie keeps the earlier, higher-ranked one.
	always_comb begin
		best_lvl = 5'h0;
		best_src = 5'h0;
		best_any = 1'b0;
		for (int k = 0; k < 22; k++) begin
			if (pend[k] && lvl[k] != 5'h0 && (k == 0 || lvl[k] > {1'b0, cpu_mask_level})
					&& (!best_any || lvl[k] > best_lvl)) begin
				best_lvl = lvl[k];
				best_src = 5'(k);
				best_any = 1'b1;
			end
		end
	end

	// On-chip requests that would win against the mask, shown on the pin.
	always_comb begin
		onchip_any = 1'b0;
		for (int j = 0; j < 12; j++)
			if (onchip_req[j] && lvl[10 + j] > {1'b0, cpu_mask_level})
				onchip_any = 1'b1;
	end
	assign onchip_pending_out = onchip_any;

	// Acceptance on a qualifying decode; address errors rank first.
	assign gate_ok = state_r == ST_RUN && dq.valid && !dq.delay_slot;
	assign acc_ae = gate_ok && ae_pend_r;
	assign acc_int = gate_ok && !dq.after_disable && !ae_pend_r && best_any;

	// Exception sequencing state.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_RUN;
		end else begin
			case (state_r)
				ST_RUN: begin
					if (acc_ae)
						state_r <= ST_AEX;
					else if (acc_int || exc_begin)
						state_r <= ST_EXC;
				end
				ST_EXC: begin
					if (exc_done)
						state_r <= ST_RUN;
				end
				ST_AEX: begin
					if (exc_done)
						state_r <= ST_RUN;
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end

	// Pending address error from stacking or vector fetch.
	always_ff @(posedge clk) begin
		if (srst)
			ae_pend_r <= 1'b0;
		else if (state_r == ST_EXC && stack_push && sp_work_r[1:0] != 2'h0)
			ae_pend_r <= 1'b1;
		else if (state_r != ST_RUN && vector_fetch && vector_base[1:0] != 2'h0)
			ae_pend_r <= 1'b1;
		else if (acc_ae)
			ae_pend_r <= 1'b0;
	end

	// Stacking pointer: every push goes out, four lower, aligned or not.
	always_ff @(posedge clk) begin
		if (srst) begin
			sp_work_r <= 32'h0;
			push_valid_r <= 1'b0;
			push_addr_r <= 32'h0;
			push_data_defined_r <= 1'b0;
		end else begin
			push_valid_r <= stack_push && state_r != ST_RUN;
			if (state_r == ST_RUN) begin
				sp_work_r <= stack_pointer;
			end else if (stack_push) begin
				sp_work_r <= sp_work_r - `STACK_STEP;
				push_addr_r <= sp_work_r - `STACK_STEP;
				push_data_defined_r <= sp_work_r[1:0] == 2'h0;
			end
		end
	end

	// Acceptance pulses toward the CPU sequencer with the taken source.
	always_ff @(posedge clk) begin
		if (srst) begin
			int_take_r <= 1'b0;
			ae_take_r <= 1'b0;
			take_src_r <= 5'h0;
			take_level_r <= 4'h0;
		end else begin
			int_take_r <= acc_int;
			ae_take_r <= acc_ae;
			if (acc_int) begin
				take_src_r <= best_src;
				take_level_r <= best_src == `SRC_NMI ? `NMI_MASK_LEVEL : best_lvl[3:0];
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_slot_blocks_all: assert property (dq.valid && dq.delay_slot |=> !int_take_r && !ae_take_r)
		else $error("exception taken in delay slot");
	a_disable_blocks_int: assert property (dq.after_disable |=> !int_take_r)
		else $error("interrupt taken after disabling instruction");
	a_disable_passes_ae: assert property (state_r == ST_RUN && dq.valid && !dq.delay_slot
			&& ae_pend_r |=> ae_take_r ##1 !ae_pend_r)
		else $error("address error not taken after disabling instruction");
	a_ae_stays_pending: assert property (ae_pend_r && !acc_ae |=> ae_pend_r)
		else $error("held address error lost");
	a_sp_misalign_err: assert property (state_r == ST_EXC && stack_push
			&& sp_work_r[1:0] != 2'h0 |=> ae_pend_r && push_valid_r)
		else $error("misaligned stack push not flagged");
	a_vec_misalign_err: assert property (state_r == ST_EXC && vector_fetch
			&& vector_base[1:0] != 2'h0 |=> ae_pend_r)
		else $error("misaligned vector base not flagged");
	a_aex_ignores_stack: assert property (state_r == ST_AEX && stack_push && !vector_fetch
			&& sp_work_r[1:0] != 2'h0 && !ae_pend_r |=> !ae_pend_r)
		else $error("stacking error not ignored in address error processing");
	a_push_step_four: assert property (state_r != ST_RUN && stack_push
			|=> push_valid_r && push_addr_r == $past(sp_work_r) - `STACK_STEP)
		else $error("stacking address not four below pointer");
	a_nmi_sets_fifteen: assert property (int_take_r && take_src_r == `SRC_NMI
			|-> take_level_r == `NMI_MASK_LEVEL)
		else $error("non-maskable take without level 15");
	a_mask_strict: assert property (acc_int && best_src != `SRC_NMI
			|=> int_take_r && {1'b0, take_level_r} > $past({1'b0, cpu_mask_level}))
		else $error("interrupt taken at or below mask");
	a_icr_pin_mirror: assert property (bus.rd && bus.size == `SIZE_WORD
			&& bus.addr[27:24] == `REG_AREA && bus.addr[8:0] == 9'h18e |=> rdata[15] == $past(nmi_pin))
		else $error("control register top bit differs from pin");

endmodule // exception_accept_and_priority_controller

// [verilog/priority_controller_pkg.sv]
/*
 * Types shared by the exception acceptance and priority controller.
 * Assumes the constants header is included by the design file.
 */
package priority_controller_pkg;

	// Exception sequencing state, one-hot.
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_EXC = 3'b010,
		ST_AEX = 3'b100
	} exc_state_t;

	// Register port request.
	typedef struct packed {
		logic [27:0] addr;
		logic [31:0] wdata;
		logic [1:0] size;
		logic wr;
		logic rd;
	} reg_bus_t;

	// Per-cycle decode qualifier from the CPU.
	typedef struct packed {
		logic valid;
		logic delay_slot;
		logic after_disable;
	} decode_qual_t;

endpackage

// [verilog/priority_controller_regs.svh]
/*
 * Offsets, field positions, reset values and fixed levels of the
 * exception acceptance and priority controller.
 * Assumes byte addresses of 28 bits and a big-endian register port.
 */
`ifndef PRIORITY_CONTROLLER_REGS_SVH
`define PRIORITY_CONTROLLER_REGS_SVH

// Printed offsets of the six registers.
`define PRIORITY_REG_A_OFS 28'h5ffff84
`define PRIORITY_REG_B_OFS 28'h5ffff86
`define PRIORITY_REG_C_OFS 28'h5ffff88
`define PRIORITY_REG_D_OFS 28'h5ffff8a
`define PRIORITY_REG_E_OFS 28'h5ffff8c
`define INPUT_DETECT_CONTROL_OFS 28'h5ffff8e

// Decoded address parts: A27-A24 and A8-A0 of the first register.
`define REG_AREA 4'h5
`define REG_LOW_BASE 9'h184

// Access sizes on the register port.
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

// Control register fields and reset values.
`define ICR_NMI_LEVEL_BIT 15
`define ICR_NMI_EDGE_BIT 8
`define PRIORITY_RESET 16'h0000
`define ICR_EDGE_RESET 1'h0
`define ICR_SENSE_RESET 8'h00

// Fixed levels and source numbering.
`define NMI_MASK_LEVEL 4'hf
`define BREAK_LEVEL 5'h0f
`define NMI_LEVEL 5'h10
`define SRC_NMI 5'h00
`define SRC_BREAK 5'h01
`define SRC_IRQ0 5'h02
`define SRC_ONCHIP0 5'h0a
`define STACK_STEP 32'h00000004

`endif
